// File: verilog/charge_state_controller.sv
/*
  Charge sequencing controller with AXI4-Lite register slave.
  Assumes all threshold flags arrive deglitched and synchronous to clk;
  the analog stage consumes the mode, level and enable outputs.
*/
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// R1 - Empty or missing battery: safe charge, then pre-charge at safe level
// R2 - Pre-charge enables converter, low current, until above pre-charge level
// R3 - Constant current uses 4-bit host charge current field
// R4 - Near target voltage switch to constant voltage; 6-bit target field
// R5 - Above recharge and current below end level: end of charge, halt
// R6 - Battery below recharge level resumes constant current charge
// R7 - End-of-charge current level is a 3-bit field, current register
// R8 - Three limit loops; first to reach its limit takes regulation
// R9 - Current, voltage and input limit changes ramp in 10 us steps
// R10 - Start only with input present and input above battery
// R11 - Report thermistor and switch presence, then start charging itself
// R12 - Clearing charge enable suspends charging into fault, any state
// R13 - In fault, clearing thermistor enable powers thermistor block down
// R14 - Registers usable without input while internal rail is adequate
// R15 - Register reset bit restores every register default anytime
// R16 - Switch drive low normally; high only for deep battery, system off; here system off is checked only on entry to weak wait
// R17 - Configuration probes switch pin; success records switch fitted
// R18 - Detection held for charge cycle; redone on unplug or reset
// R19 - Weak wait from wait only: switch fitted, below threshold, mode low
// R20 - Flags taken as synchronous; transitions on clock edge
module charge_state_controller (
  input  wire logic        clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Comparator flags
  input  wire logic        input_present,
  input  wire logic        input_above_battery,
  input  wire logic        rail_above_undervoltage,
  input  wire logic        bat_above_safe,
  input  wire logic        bat_above_pre,
  input  wire logic        bat_above_recharge,
  input  wire logic        bat_near_charge_voltage,
  input  wire logic        current_below_eoc,
  input  wire logic        bat_above_switch_threshold,
  input  wire logic        switch_probe_reached,
  input  wire logic        thermistor_sense,
  input  wire logic        system_power_mode_input,
  input  wire logic        iin_at_limit,
  input  wire logic        charge_current_field_at_limit,
  input  wire logic        vchg_at_limit,
  // Power stage controls
  output logic             converter_en,
  output logic [1:0]       current_mode,
  output logic [3:0]       charge_current_level,
  output logic [5:0]       charge_voltage_level,
  output logic [2:0]       input_limit_level,
  output logic [2:0]       eoc_current_level,
  output logic [2:0]       switch_threshold_level,
  output logic             cv_mode,
  output logic [1:0]       active_loop,
  output logic             battery_switch_drive,
  output logic             switch_probe_en,
  output logic             thermistor_power
);

  // Whole controller state; one comb image, one register stage
  typedef struct packed {
    charger_pkg::phase_t    phase;
    logic                   charge_enable_bit;
    logic                   thermistor_enable_bit;
    logic [3:0]             charge_current_field;
    logic [2:0]             end_of_charge_current_field;
    logic [5:0]             vchg;
    logic [2:0]             vfet;
    logic [2:0]             iin;
    logic                   fet_fitted;
    logic                   ntc_seen;
    logic [7:0]             step_cnt;
    logic                   step_en;
    logic                   aw_held;
    logic [7:0]             aw_addr;
    logic                   w_held;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic                   conv_en;
    charger_pkg::cur_mode_t cur_mode;
    logic                   cv;
    charger_pkg::loop_t     loop;
    logic                   sw_drive;
    logic                   probe_en;
    logic                   ntc_pwr;
  } ctl_st_t;

  ctl_st_t r;
  ctl_st_t n;

  // Next state: bus slave, register file, phase sequencer, outputs
  always_comb begin
    logic        unplug;
    logic        reg_rst;
    logic        loop_held;
    logic [31:0] status;
    unplug    = !input_present || !input_above_battery;
    reg_rst   = 1'b0;
    loop_held = 1'b0;
    status    = '0;
    n         = r;

    // Status word; phase code sits below the mode bit
    status[charger_pkg::ST_CV_BIT-1:0]    = r.phase;
    status[charger_pkg::ST_CV_BIT]        = r.cv;
    status[charger_pkg::ST_FET_BIT]       = r.fet_fitted; // R11
    status[charger_pkg::ST_NTC_BIT]       = r.ntc_seen; // R11
    status[charger_pkg::ST_LOOP_LSB +: 2] = r.loop;

    // Ramp step enable, one pulse per step time
    n.step_en = 1'b0;
    if (r.step_cnt == charger_pkg::STEP_LAST) begin
      n.step_cnt = '0;
      n.step_en  = 1'b1; // R9
    end else begin
      n.step_cnt = r.step_cnt + 8'h01;
    end

    // Address and data may arrive in either order; each is held
    if (s_axi_awvalid && r.awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_held = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end

    // Both halves held: apply the write and answer it
    // Limitation: a write without byte 0 strobed changes nothing
    if (r.aw_held && r.w_held && !r.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = charger_pkg::RESP_OKAY;
      if (r.w_strb[0]) begin
        case (r.aw_addr)
          charger_pkg::OFS_CTRL: begin
            reg_rst  = r.w_data[charger_pkg::REG_RST_BIT]; // R15
            n.charge_enable_bit = r.w_data[charger_pkg::CHARGE_ENABLE_BIT_BIT]; // R12
            n.thermistor_enable_bit = r.w_data[charger_pkg::THERMISTOR_ENABLE_BIT_BIT]; // R13
          end
          charger_pkg::OFS_IBAT: begin
            n.charge_current_field = r.w_data[charger_pkg::CHARGE_CURRENT_FIELD_LSB +: 4]; // R3
            n.end_of_charge_current_field = r.w_data[charger_pkg::END_OF_CHARGE_CURRENT_FIELD_LSB +: 3]; // R7
          end
          charger_pkg::OFS_VBAT: n.vchg = r.w_data[charger_pkg::VCHG_LSB +: 6];
          charger_pkg::OFS_MISC: begin
            n.vfet = r.w_data[charger_pkg::VFET_LSB +: 3]; // R16
            n.iin  = r.w_data[charger_pkg::IIN_LSB +: 3];
          end
          // Status is read-only; a write is refused, not ignored
          charger_pkg::OFS_STATUS: n.bresp = charger_pkg::RESP_SLVERR;
          default: n.bresp = charger_pkg::RESP_DECERR;
        endcase
      end
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Ready only with the internal rail up, input supply or not
    n.awready = rail_above_undervoltage && s_axi_awvalid && !r.awready
                && !n.aw_held && !n.bvalid; // R14
    n.wready  = rail_above_undervoltage && s_axi_wvalid && !r.wready
                && !n.w_held && !n.bvalid; // R14

    // Read data is captured at the address handshake
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = charger_pkg::RESP_OKAY;
      n.rdata  = '0;
      case (s_axi_araddr)
        charger_pkg::OFS_CTRL: begin
          n.rdata[charger_pkg::CHARGE_ENABLE_BIT_BIT] = r.charge_enable_bit;
          n.rdata[charger_pkg::THERMISTOR_ENABLE_BIT_BIT] = r.thermistor_enable_bit;
        end
        charger_pkg::OFS_IBAT: begin
          n.rdata[charger_pkg::CHARGE_CURRENT_FIELD_LSB +: 4] = r.charge_current_field;
          n.rdata[charger_pkg::END_OF_CHARGE_CURRENT_FIELD_LSB +: 3] = r.end_of_charge_current_field;
        end
        charger_pkg::OFS_VBAT: n.rdata[charger_pkg::VCHG_LSB +: 6] = r.vchg;
        charger_pkg::OFS_MISC: begin
          n.rdata[charger_pkg::VFET_LSB +: 3] = r.vfet;
          n.rdata[charger_pkg::IIN_LSB +: 3]  = r.iin;
        end
        charger_pkg::OFS_STATUS: n.rdata = status; // R11
        default: n.rresp = charger_pkg::RESP_DECERR;
      endcase
    end
    n.arready = rail_above_undervoltage && s_axi_arvalid && !r.arready
                && !n.rvalid; // R14

    // Phase sequencer
    case (r.phase)
      charger_pkg::PH_OFF: begin
        n.phase = charger_pkg::PH_CONFIG; // R10
      end
      charger_pkg::PH_CONFIG: begin
        // Probe result is kept until the next unplug or reset
        n.fet_fitted = switch_probe_reached; // R17 R18
        n.ntc_seen   = thermistor_sense; // R11
        n.phase      = charger_pkg::PH_WAIT; // R11
      end
      charger_pkg::PH_WAIT: begin
        if (r.fet_fitted && !bat_above_switch_threshold
            && !system_power_mode_input) begin
          n.phase = charger_pkg::PH_WEAK_WAIT; // R19
        end else begin
          n.phase = charger_pkg::PH_SAFE;
        end
      end
      // Weak battery handling beyond entry is not part of this block
      charger_pkg::PH_WEAK_WAIT: begin
        n.phase = charger_pkg::PH_WEAK_WAIT;
      end
      charger_pkg::PH_SAFE: begin
        n.phase = bat_above_safe ? charger_pkg::PH_PRE : r.phase; // R1
      end
      charger_pkg::PH_PRE: begin
        n.phase = bat_above_pre ? charger_pkg::PH_FULL : r.phase; // R2
      end
      charger_pkg::PH_FULL: begin
        if (bat_above_recharge && current_below_eoc) begin
          n.phase = charger_pkg::PH_EOC; // R5
        end
      end
      charger_pkg::PH_EOC: begin
        if (!bat_above_recharge) begin
          n.phase = charger_pkg::PH_FULL; // R6
        end
      end
      charger_pkg::PH_FAULT: begin
        n.phase = r.charge_enable_bit ? charger_pkg::PH_WAIT : r.phase;
      end
      default: begin
        n.phase = charger_pkg::PH_OFF;
      end
    endcase
    // Host hold beats the sequence; unplug beats everything
    if (!r.charge_enable_bit) begin
      n.phase = charger_pkg::PH_FAULT; // R12
    end
    if (reg_rst) begin
      n.phase = charger_pkg::PH_CONFIG; // R18
    end
    if (unplug) begin
      n.phase = charger_pkg::PH_OFF; // R10 R18
    end

    // Power stage controls follow the coming phase
    n.conv_en = (n.phase == charger_pkg::PH_PRE)
                || (n.phase == charger_pkg::PH_FULL); // R2 R3
    case (n.phase)
      charger_pkg::PH_SAFE: n.cur_mode = charger_pkg::CUR_SAFE; // R1
      charger_pkg::PH_PRE:  n.cur_mode = charger_pkg::CUR_PRE; // R2
      charger_pkg::PH_FULL: n.cur_mode = charger_pkg::CUR_CHG; // R3
      default:              n.cur_mode = charger_pkg::CUR_NONE; // R5
    endcase
    n.cv = (n.phase == charger_pkg::PH_FULL)
           && bat_near_charge_voltage; // R4

    // First loop at its limit keeps control until it lets go
    loop_held = (r.loop == charger_pkg::LOOP_IIN && iin_at_limit)
                || (r.loop == charger_pkg::LOOP_CHARGE_CURRENT_FIELD && charge_current_field_at_limit)
                || (r.loop == charger_pkg::LOOP_VCHG && vchg_at_limit);
    if (!n.conv_en) begin
      n.loop = charger_pkg::LOOP_NONE;
    end else if (loop_held) begin
      n.loop = r.loop; // R8
    end else if (iin_at_limit) begin
      n.loop = charger_pkg::LOOP_IIN; // R8
    end else if (charge_current_field_at_limit) begin
      n.loop = charger_pkg::LOOP_CHARGE_CURRENT_FIELD;
    end else if (vchg_at_limit) begin
      n.loop = charger_pkg::LOOP_VCHG;
    end else begin
      n.loop = charger_pkg::LOOP_NONE;
    end

    // Switch opens for a deep battery in weak wait; system off is needed only to enter weak wait
    n.sw_drive = (n.phase == charger_pkg::PH_WEAK_WAIT)
                 && !bat_above_switch_threshold; // R16
    n.probe_en = (n.phase == charger_pkg::PH_CONFIG); // R17
    // Thermistor block may sleep only while held in fault
    n.ntc_pwr  = !((n.phase == charger_pkg::PH_FAULT) && !n.thermistor_enable_bit); // R13

    // Synchronous reset to the off phase
    if (!resetn) begin
      n         = '0;
      n.phase   = charger_pkg::PH_OFF;
      n.ntc_pwr = 1'b1;
    end
    // Register defaults on reset and on the register reset bit
    if (!resetn || reg_rst) begin
      n.charge_enable_bit = charger_pkg::CHARGE_ENABLE_BIT_RST; // R15
      n.thermistor_enable_bit = charger_pkg::THERMISTOR_ENABLE_BIT_RST;
      n.charge_current_field   = charger_pkg::CHARGE_CURRENT_FIELD_RST;
      n.end_of_charge_current_field   = charger_pkg::END_OF_CHARGE_CURRENT_FIELD_RST;
      n.vchg   = charger_pkg::VCHG_RST;
      n.vfet   = charger_pkg::VFET_RST;
      n.iin    = charger_pkg::IIN_RST;
    end
  end

  // All transitions on the clock edge; flags are already clean
  always_ff @(posedge clk) begin // R20
    r <= n;
  end

  // Setpoints move one code per step toward the host value
  level_ramp #(.W(4)) i_charge_current_field_ramp (
    .clk     (clk),
    .resetn  (resetn),
    .step_en (r.step_en),
    .target  (r.charge_current_field),
    .level   (charge_current_level)
  ); // R3 R9
  level_ramp #(.W(6)) i_vchg_ramp (
    .clk     (clk),
    .resetn  (resetn),
    .step_en (r.step_en),
    .target  (r.vchg),
    .level   (charge_voltage_level)
  ); // R4 R9
  level_ramp #(.W(3)) i_iin_ramp (
    .clk     (clk),
    .resetn  (resetn),
    .step_en (r.step_en),
    .target  (r.iin),
    .level   (input_limit_level)
  ); // R9

  // Every output comes straight from a register bit
  assign s_axi_awready          = r.awready;
  assign s_axi_wready           = r.wready;
  assign s_axi_bvalid           = r.bvalid;
  assign s_axi_bresp            = r.bresp;
  assign s_axi_arready          = r.arready;
  assign s_axi_rvalid           = r.rvalid;
  assign s_axi_rdata            = r.rdata;
  assign s_axi_rresp            = r.rresp;
  assign converter_en           = r.conv_en;
  assign current_mode           = r.cur_mode;
  assign eoc_current_level      = r.end_of_charge_current_field; // R7
  assign switch_threshold_level = r.vfet;
  assign cv_mode                = r.cv;
  assign active_loop            = r.loop;
  assign battery_switch_drive   = r.sw_drive;
  assign switch_probe_en        = r.probe_en;
  assign thermistor_power       = r.ntc_pwr;

endmodule // charge_state_controller

// File: verilog/charger_pkg.sv
/*
  Shared constants for the charge sequencing controller: register map,
  field positions, reset values, phase and mode codes, ramp timing.
  Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package charger_pkg;

  // Ramp step timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_TIME_NS  = 10000;
  localparam int STEP_CYCLES   = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_IBAT   = 8'h04;
  localparam logic [7:0] OFS_VBAT   = 8'h08;
  localparam logic [7:0] OFS_MISC   = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Field positions
  localparam int CHARGE_ENABLE_BIT_BIT  = 0;
  localparam int THERMISTOR_ENABLE_BIT_BIT  = 1;
  localparam int REG_RST_BIT = 2;
  localparam int CHARGE_CURRENT_FIELD_LSB    = 0;
  localparam int END_OF_CHARGE_CURRENT_FIELD_LSB    = 4;
  localparam int VCHG_LSB    = 0;
  localparam int VFET_LSB    = 0;
  localparam int IIN_LSB     = 4;
  localparam int ST_CV_BIT   = 4;
  localparam int ST_FET_BIT  = 5;
  localparam int ST_NTC_BIT  = 6;
  localparam int ST_LOOP_LSB = 7;

  // Reset values
  localparam logic       CHARGE_ENABLE_BIT_RST = 1'h1;
  localparam logic       THERMISTOR_ENABLE_BIT_RST = 1'h1;
  localparam logic [3:0] CHARGE_CURRENT_FIELD_RST   = 4'h0;
  localparam logic [2:0] END_OF_CHARGE_CURRENT_FIELD_RST   = 3'h0;
  localparam logic [5:0] VCHG_RST   = 6'h00;
  localparam logic [2:0] VFET_RST   = 3'h0;
  localparam logic [2:0] IIN_RST    = 3'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    PH_OFF       = 4'h0,
    PH_CONFIG    = 4'h1,
    PH_WAIT      = 4'h2,
    PH_WEAK_WAIT = 4'h3,
    PH_SAFE      = 4'h4,
    PH_PRE       = 4'h5,
    PH_FULL      = 4'h6,
    PH_EOC       = 4'h7,
    PH_FAULT     = 4'h8
  } phase_t;

  typedef enum logic [1:0] {
    CUR_NONE = 2'h0,
    CUR_SAFE = 2'h1,
    CUR_PRE  = 2'h2,
    CUR_CHG  = 2'h3
  } cur_mode_t;

  typedef enum logic [1:0] {
    LOOP_NONE = 2'h0,
    LOOP_IIN  = 2'h1,
    LOOP_CHARGE_CURRENT_FIELD = 2'h2,
    LOOP_VCHG = 2'h3
  } loop_t;

endpackage

// File: verilog/level_ramp.sv
/*
  One stepped setpoint: moves its level one code toward the target on
  each step enable pulse. Assumes step_en is a one-cycle pulse.
*/
`timescale 1ns/1ns
module level_ramp #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         step_en,
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] level;
  } ramp_st_t;

  ramp_st_t r;
  ramp_st_t n;

  // One code per step keeps setpoint changes gentle
  always_comb begin
    n = r;
    if (step_en) begin
      if (r.level < target) begin
        n.level = r.level + W'(1);
      end else if (r.level > target) begin
        n.level = r.level - W'(1);
      end
    end
    if (!resetn) begin
      n = '0;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  assign level = r.level;

endmodule // level_ramp

// File: sim/host_axi_model.sv
/* Host master on the register bus.
   Assumes the slave shares clk. */
`timescale 1ns/1ns
module host_axi_model (
  input  wire logic        clk,
  input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid,
  input  wire logic        s_axi_arready, s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready,
  output logic             s_axi_arvalid, s_axi_rready,
  output logic [7:0]       s_axi_awaddr, s_axi_araddr,
  output logic [31:0]      s_axi_wdata
);
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
  initial {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
  // Address and data offered together; each drops once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready ||
               s_axi_wvalid && !s_axi_wready);
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  // No cycle count assumed; the bench watchdog ends a hang
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    {v, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule // host_axi_model

// File: sim/charger_chk.sv
/* Port checker for the charge controller.
   Assumes one clock and synchronous reset. */
`timescale 1ns/1ns
module charger_chk (
  input wire logic       clk, resetn, converter_en, cv_mode, input_present,
  input wire logic       battery_switch_drive, bat_above_switch_threshold,
  input wire logic       s_axi_bvalid, s_axi_bready,
  input wire logic [1:0] current_mode,
  input wire logic [3:0] charge_current_level,
  input wire logic [5:0] charge_voltage_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Converter on in both charging phases
  pre_conv_a: assert property (current_mode == charger_pkg::CUR_PRE
    |-> converter_en) else $error("pre without converter");
  cc_conv_a: assert property (current_mode == charger_pkg::CUR_CHG
    |-> converter_en) else $error("cc without converter");
  cv_full_a: assert property (cv_mode
    |-> current_mode == charger_pkg::CUR_CHG) else $error("cv out");
  switch_low_a: assert property (bat_above_switch_threshold [*2]
    |-> !battery_switch_drive) else $error("switch high");
  // Charge current level moves one code; both setpoints then hold for eight cycles
  charge_current_field_step_a: assert property ($changed(charge_current_level)
    |-> (charge_current_level - $past(charge_current_level)) inside
    {4'h1, 4'hf} ##1 $stable(charge_current_level) [*8])
    else $error("charge_current_field jump");
  vchg_step_a: assert property ($changed(charge_voltage_level)
    |=> $stable(charge_voltage_level) [*8]) else $error("vchg jump");
  no_input_a: assert property (!input_present [*3]
    |-> current_mode == charger_pkg::CUR_NONE) else $error("no input");
  bhold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  cover property (cv_mode);
  cover property (current_mode == charger_pkg::CUR_PRE);
  cover property ($changed(charge_current_level));
endmodule // charger_chk
bind charge_state_controller charger_chk i_chk (.*);

// File: sim/charge_state_controller_bench.sv
/* Scenario bench for the charge controller.
   Assumes the host model and bound checker. */
`timescale 1ns/1ns
module charge_state_controller_bench;
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, input_present, input_above_battery;
  logic rail_above_undervoltage, bat_above_safe, bat_above_pre;
  logic bat_above_recharge, bat_near_charge_voltage, current_below_eoc;
  logic bat_above_switch_threshold, switch_probe_reached, thermistor_sense;
  logic system_power_mode_input, iin_at_limit, charge_current_field_at_limit, vchg_at_limit;
  logic converter_en, cv_mode, battery_switch_drive, switch_probe_en;
  logic thermistor_power;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, charge_current_level;
  logic [1:0] s_axi_bresp, s_axi_rresp, current_mode, active_loop, r;
  logic [5:0] charge_voltage_level;
  logic [2:0] input_limit_level, eoc_current_level, switch_threshold_level;
  int bad_count, checks_done;
  charge_state_controller i_dut (.*);
  host_axi_model i_host (.*);
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic settle;
    repeat (40) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Start needs both input flags, then phases follow the battery
  task automatic t_start;
    settle;
    input_present <= 1'b1;
    settle;
    chk(converter_en === 1'b0, "early start");
    input_above_battery <= 1'b1;
    settle;
    chk(current_mode === charger_pkg::CUR_SAFE, "safe");
    i_host.rd(charger_pkg::OFS_STATUS, d, r);
    chk(d[6:5] === 2'h3, "presence");
    bat_above_safe <= 1'b1;
    settle;
    chk(current_mode === charger_pkg::CUR_PRE, "pre");
    {bat_above_pre, bat_above_switch_threshold} <= 2'h3;
    settle;
    chk(current_mode === charger_pkg::CUR_CHG, "cc");
    chk(battery_switch_drive === 1'b0, "switch");
    charge_current_field_at_limit <= 1'b1;
    settle;
    iin_at_limit <= 1'b1;
    settle;
    chk(active_loop === charger_pkg::LOOP_CHARGE_CURRENT_FIELD, "loop");
    $display("t_start done");
  endtask
  // Current field ramps; a nine-code move cannot land at once
  task automatic t_regs;
    i_host.wr(charger_pkg::OFS_IBAT, 32'h00000059);
    repeat (20) @(posedge clk);
    chk(charge_current_level !== 4'h9, "jump");
    i_host.wr(charger_pkg::OFS_VBAT, 32'h00000003);
    i_host.wr(charger_pkg::OFS_MISC, 32'h00000015);
    repeat (10 * charger_pkg::STEP_CYCLES) @(posedge clk);
    chk(charge_current_level === 4'h9, "charge_current_field");
    chk(eoc_current_level === 3'h5, "end_of_charge_current_field");
    chk(charge_voltage_level === 6'h03, "vchg");
    chk(input_limit_level === 3'h1, "iin");
    chk(switch_threshold_level === 3'h5, "vfet");
    i_host.rd(8'h20, d, r);
    chk(r !== charger_pkg::RESP_OKAY, "unmapped");
    $display("t_regs done");
  endtask
  // Constant voltage, end of charge and recharge
  task automatic t_eoc;
    bat_near_charge_voltage <= 1'b1;
    settle;
    chk(cv_mode === 1'b1, "cv");
    {bat_above_recharge, current_below_eoc} <= 2'h3;
    settle;
    chk(current_mode === charger_pkg::CUR_NONE, "eoc");
    bat_above_recharge <= 1'b0;
    settle;
    chk(current_mode === charger_pkg::CUR_CHG, "rechg");
    $display("t_eoc done");
  endtask
  // Host suspends, powers thermistor down, then resets registers
  task automatic t_fault;
    i_host.wr(charger_pkg::OFS_CTRL, 32'h00000002);
    settle;
    chk(current_mode === charger_pkg::CUR_NONE, "fault");
    i_host.wr(charger_pkg::OFS_CTRL, 32'h00000000);
    settle;
    chk(thermistor_power === 1'b0, "ntc");
    input_present <= 1'b0;
    i_host.wr(charger_pkg::OFS_CTRL, 32'h00000004);
    i_host.rd(charger_pkg::OFS_IBAT, d, r);
    chk(d[6:0] === {charger_pkg::END_OF_CHARGE_CURRENT_FIELD_RST, charger_pkg::CHARGE_CURRENT_FIELD_RST}, "rst");
    $display("t_fault done");
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {resetn, input_present, input_above_battery, bat_above_safe} = '0;
    {bat_above_pre, bat_above_recharge, bat_near_charge_voltage} = '0;
    {current_below_eoc, bat_above_switch_threshold, iin_at_limit} = '0;
    {charge_current_field_at_limit, vchg_at_limit} = '0;
    {rail_above_undervoltage, switch_probe_reached, thermistor_sense} = '1;
    {system_power_mode_input, s_axi_wstrb} = '1;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_start;
    t_regs;
    t_eoc;
    t_fault;
    wrap_up;
  end
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    bad_count++;
    wrap_up;
  end
endmodule // charge_state_controller_bench
